/* include/iapf_defs.svh */
// Constants of the in-application flash program controller
`ifndef IAPF_DEFS_SVH
`define IAPF_DEFS_SVH

// ==================================================
// Register offsets
`define IAPF_OFF_CTRL0   4'h0
`define IAPF_OFF_RSTPAT  4'h1
`define IAPF_OFF_CTRL2   4'h2
`define IAPF_OFF_ADRL    4'h3
`define IAPF_OFF_ADRH    4'h4
`define IAPF_OFF_DAT0L   4'h5
`define IAPF_OFF_DAT0H   4'h6
`define IAPF_OFF_DATLAST 4'hc

// ==================================================
// Field positions
`define IAPF_C0_FLAG     7
`define IAPF_C0_MODE_HI  6
`define IAPF_C0_MODE_LO  4
`define IAPF_C0_TRIG     3
`define IAPF_C0_WINIT    2
`define IAPF_C0_RDEN     1
`define IAPF_C0_RINIT    0
`define IAPF_C2_TSEL     1
`define IAPF_C2_CLR      0
`define IAPF_PAGE_MSB    11
`define IAPF_PAGE_LSB    5

// ==================================================
// Reset values
`define IAPF_BYTE_RST    8'h00
`define IAPF_WORD_RST    16'h0000
`define IAPF_ADDR_RST    12'h000

// ==================================================
// Sizes and timing
`define IAPF_PAGE_WORDS  32
`define IAPF_WORD_W      16
`define IAPF_ADDR_W      12
`define IAPF_FIFO_DEPTH  4
`define IAPF_CLK_MHZ     250
`define IAPF_T_ERASE0_US 3200
`define IAPF_T_ERASE1_US 3700
`define IAPF_T_WRITE0_US 2200
`define IAPF_T_WRITE1_US 3000
`define IAPF_ENABLE_CYC  1024

`endif

/* include/iapf_pkg.sv */
// Types of the in-application flash program controller
package iapf_pkg;

  typedef enum logic [2:0] {
    IAPF_MODE_WRITE  = 3'h0,
    IAPF_MODE_ERASE  = 3'h1,
    IAPF_MODE_READ   = 3'h3,
    IAPF_MODE_ENABLE = 3'h6
  } iapf_mode_t;

  typedef enum logic [2:0] {
    IAPF_ST_IDLE  = 3'h0,
    IAPF_ST_ERASE = 3'h1,
    IAPF_ST_LOAD  = 3'h2,
    IAPF_ST_DRAIN = 3'h3,
    IAPF_ST_PROG  = 3'h4,
    IAPF_ST_READ  = 3'h5
  } iapf_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } iapf_reg_req_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
  } iapf_word_t;

endpackage : iapf_pkg

/* hw/iapf_ctrl.sv */
// Flash program controller with page write buffer and word FIFO
`timescale 1ns/1ps
`include "iapf_defs.svh"

// ==================================================
// Word FIFO
module iapf_fifo #(
  parameter int W = `IAPF_WORD_W,
  parameter int D = `IAPF_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [CW-1:0] cnt_reg;
  logic          push;
  logic          pop;

  function automatic logic [PW-1:0] wrap(input logic [PW-1:0] p);
    return (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : wrap

  assign in_ready  = (cnt_reg != CW'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wrap(wptr_reg);
      end
      if (pop) begin
        rptr_reg <= wrap(rptr_reg);
      end
      cnt_reg <= CW'(cnt_reg + CW'(push) - CW'(pop));
    end
  end
endmodule : iapf_fifo

// ==================================================
// Controller
module iapf_ctrl
  import iapf_pkg::*;
#(
  parameter int unsigned        PAGE_WORDS  = `IAPF_PAGE_WORDS,
  parameter int unsigned        FIFO_DEPTH  = `IAPF_FIFO_DEPTH,
  parameter int unsigned        ERASE0_CYC  = `IAPF_T_ERASE0_US * `IAPF_CLK_MHZ,
  parameter int unsigned        ERASE1_CYC  = `IAPF_T_ERASE1_US * `IAPF_CLK_MHZ,
  parameter int unsigned        WRITE0_CYC  = `IAPF_T_WRITE0_US * `IAPF_CLK_MHZ,
  parameter int unsigned        WRITE1_CYC  = `IAPF_T_WRITE1_US * `IAPF_CLK_MHZ,
  parameter int unsigned        ENABLE_CYC  = `IAPF_ENABLE_CYC,
  // Unlock patterns, values arbitrary
  parameter logic [15:0]        UNLOCK_PAT1 = 16'h1234,
  parameter logic [15:0]        UNLOCK_PAT2 = 16'h5678,
  parameter logic [15:0]        UNLOCK_PAT3 = 16'h9abc
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire iapf_reg_req_t    reg_req,
  output logic [7:0]            reg_rdata,
  output logic                  cpu_halt,
  output logic                  flash_erase,
  output logic                  flash_prog,
  output logic [6:0]            flash_page,
  output iapf_word_t            flash_wr,
  output logic                  flash_wr_valid,
  input  wire logic             flash_wr_ready,
  output logic                  flash_rd_req,
  output logic [11:0]           flash_rd_addr,
  input  wire logic             flash_rd_valid,
  input  wire logic [15:0]      flash_rd_data
);
  localparam int IW = $clog2(PAGE_WORDS);

  // ==================================================
  // State
  iapf_state_t state_reg;
  logic [31:0] timer_reg;
  logic [IW-1:0] idx_reg;
  logic [15:0] en_cnt_reg;

  logic        flag_reg;
  iapf_mode_t  mode_reg;
  logic        trig_reg;
  logic        winit_reg;
  logic        rden_reg;
  logic        rinit_reg;
  logic        tsel_reg;
  logic        clr_reg;
  logic [7:0]  rstpat_reg;
  logic [11:0] addr_reg;
  logic [15:0] data_reg [4];
  logic [15:0] wbuf [PAGE_WORDS];

  logic        idle;
  logic        wr_start;
  logic        rd_start;
  logic        erase_done;
  logic        prog_done;
  logic        read_done;
  logic        load_ok;
  logic        en_match;
  logic        en_timeout;
  logic        fifo_in_ready;
  iapf_word_t  fifo_in;
  logic [27:0] fifo_out;

  // ==================================================
  // Decoding
  function automatic logic wr_hit(input iapf_reg_req_t r, input logic [3:0] off);
    return r.wr && (r.addr == off);
  endfunction : wr_hit

  function automatic logic [31:0] limit(input int unsigned cyc);
    return (cyc > 1) ? 32'(cyc - 1) : 32'h0;
  endfunction : limit

  assign idle = (state_reg == IAPF_ST_IDLE);
  assign wr_start = idle && winit_reg && flag_reg &&
                    (mode_reg == IAPF_MODE_WRITE || mode_reg == IAPF_MODE_ERASE);
  assign rd_start = idle && rinit_reg && rden_reg && (mode_reg == IAPF_MODE_READ);
  assign erase_done = (state_reg == IAPF_ST_ERASE) && (timer_reg == 32'h0);
  assign prog_done  = (state_reg == IAPF_ST_PROG) && (timer_reg == 32'h0);
  assign read_done  = (state_reg == IAPF_ST_READ) && flash_rd_valid;
  assign load_ok    = wr_hit(reg_req, `IAPF_OFF_DAT0H) && flag_reg && idle;
  assign en_match   = (data_reg[1] == UNLOCK_PAT1) && (data_reg[2] == UNLOCK_PAT2) &&
                      (data_reg[3] == UNLOCK_PAT3);
  assign en_timeout = (en_cnt_reg == 16'(ENABLE_CYC - 1));

  // ==================================================
  // Operation sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= IAPF_ST_IDLE;
      timer_reg <= 32'h0;
      idx_reg   <= '0;
    end else begin
      case (state_reg)
        IAPF_ST_IDLE: begin
          idx_reg <= '0;
          if (wr_start && mode_reg == IAPF_MODE_ERASE) begin
            state_reg <= IAPF_ST_ERASE;
            timer_reg <= tsel_reg ? limit(ERASE1_CYC) : limit(ERASE0_CYC);
          end else if (wr_start) begin
            state_reg <= IAPF_ST_LOAD;
          end else if (rd_start) begin
            state_reg <= IAPF_ST_READ;
          end
        end
        IAPF_ST_ERASE: begin
          if (erase_done) begin
            state_reg <= IAPF_ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        IAPF_ST_LOAD: begin
          if (fifo_in_ready) begin
            idx_reg <= IW'(idx_reg + 1'b1);
            if (idx_reg == IW'(PAGE_WORDS - 1)) begin
              state_reg <= IAPF_ST_DRAIN;
            end
          end
        end
        IAPF_ST_DRAIN: begin
          if (!flash_wr_valid) begin
            state_reg <= IAPF_ST_PROG;
            timer_reg <= tsel_reg ? limit(WRITE1_CYC) : limit(WRITE0_CYC);
          end
        end
        IAPF_ST_PROG: begin
          if (prog_done) begin
            state_reg <= IAPF_ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        IAPF_ST_READ: begin
          if (read_done) begin
            state_reg <= IAPF_ST_IDLE;
          end
        end
        default: begin
          state_reg <= IAPF_ST_IDLE;
        end
      endcase
    end
  end

  assign cpu_halt      = !idle;
  assign flash_erase   = (state_reg == IAPF_ST_ERASE);
  assign flash_prog    = (state_reg == IAPF_ST_PROG);
  assign flash_page    = addr_reg[`IAPF_PAGE_MSB:`IAPF_PAGE_LSB];
  assign flash_rd_req  = (state_reg == IAPF_ST_READ);
  assign flash_rd_addr = addr_reg;

  // ==================================================
  // Page streaming through the word FIFO
  assign fifo_in.addr = {addr_reg[`IAPF_PAGE_MSB:`IAPF_PAGE_LSB], idx_reg};
  assign fifo_in.data = wbuf[idx_reg];

  iapf_fifo #(
    .W (28),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (state_reg == IAPF_ST_LOAD),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (flash_wr_valid),
    .out_ready (flash_wr_ready),
    .out_data  (fifo_out)
  );

  assign flash_wr = iapf_word_t'(fifo_out);

  // ==================================================
  // Control register 0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_reg  <= 1'b0;
      mode_reg  <= IAPF_MODE_WRITE;
      trig_reg  <= 1'b0;
      winit_reg <= 1'b0;
      rden_reg  <= 1'b0;
      rinit_reg <= 1'b0;
    end else begin
      if (wr_hit(reg_req, `IAPF_OFF_CTRL0) && idle) begin
        mode_reg <= iapf_mode_t'(reg_req.wdata[`IAPF_C0_MODE_HI:`IAPF_C0_MODE_LO]);
        rden_reg <= reg_req.wdata[`IAPF_C0_RDEN];
        if (reg_req.wdata[`IAPF_C0_WINIT]) begin
          winit_reg <= 1'b1;
        end
        if (reg_req.wdata[`IAPF_C0_RINIT]) begin
          rinit_reg <= 1'b1;
        end
        if (reg_req.wdata[`IAPF_C0_TRIG]) begin
          trig_reg <= 1'b1;
        end
        if (!reg_req.wdata[`IAPF_C0_FLAG]) begin
          flag_reg <= 1'b0;
        end
      end
      // Refused starts drop at once; finished ones at completion
      if ((idle && winit_reg && !wr_start) || erase_done || prog_done) begin
        winit_reg <= 1'b0;
      end
      if ((idle && rinit_reg && !rd_start) || read_done) begin
        rinit_reg <= 1'b0;
      end
      if (trig_reg && (mode_reg != IAPF_MODE_ENABLE || en_match || en_timeout)) begin
        trig_reg <= 1'b0;
      end
      if (trig_reg && mode_reg == IAPF_MODE_ENABLE && en_match) begin
        flag_reg <= 1'b1;
      end
    end
  end

  // ==================================================
  // Enable procedure timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_cnt_reg <= 16'h0000;
    end else if (trig_reg && mode_reg == IAPF_MODE_ENABLE) begin
      en_cnt_reg <= en_cnt_reg + 16'h1;
    end else begin
      en_cnt_reg <= 16'h0000;
    end
  end

  // ==================================================
  // Control register 2 and write buffer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tsel_reg <= 1'b0;
      clr_reg  <= 1'b0;
    end else begin
      if (clr_reg) begin
        clr_reg <= 1'b0;
      end
      if (wr_hit(reg_req, `IAPF_OFF_CTRL2) && idle) begin
        tsel_reg <= reg_req.wdata[`IAPF_C2_TSEL];
        if (reg_req.wdata[`IAPF_C2_CLR]) begin
          clr_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clr_reg || prog_done) begin
      for (int i = 0; i < int'(PAGE_WORDS); i++) begin
        wbuf[i] <= `IAPF_WORD_RST;
      end
    end else if (load_ok) begin
      wbuf[addr_reg[IW-1:0]] <= {reg_req.wdata, data_reg[0][7:0]};
    end
  end

  // ==================================================
  // Address registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_reg <= `IAPF_ADDR_RST;
    end else if (load_ok) begin
      if (addr_reg[IW-1:0] != IW'(PAGE_WORDS - 1)) begin
        addr_reg <= addr_reg + 12'h001;
      end
    end else if (idle && wr_hit(reg_req, `IAPF_OFF_ADRL)) begin
      addr_reg[7:0] <= reg_req.wdata;
    end else if (idle && wr_hit(reg_req, `IAPF_OFF_ADRH)) begin
      addr_reg[11:8] <= reg_req.wdata[3:0];
    end
  end

  // ==================================================
  // Data register pairs and reset pattern
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        data_reg[i] <= `IAPF_WORD_RST;
      end
    end else if (read_done) begin
      data_reg[0] <= flash_rd_data;
    end else if (reg_req.wr && idle && reg_req.addr >= `IAPF_OFF_DAT0L &&
                 reg_req.addr <= `IAPF_OFF_DATLAST) begin
      if (reg_req.addr[0]) begin
        data_reg[2'(4'(reg_req.addr - `IAPF_OFF_DAT0L) >> 1)][7:0] <= reg_req.wdata;
      end else begin
        data_reg[2'(4'(reg_req.addr - `IAPF_OFF_DAT0L) >> 1)][15:8] <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rstpat_reg <= `IAPF_BYTE_RST;
    end else if (wr_hit(reg_req, `IAPF_OFF_RSTPAT)) begin
      rstpat_reg <= reg_req.wdata;
    end
  end

  // ==================================================
  // Read-back, one port for direct and indirect access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= `IAPF_BYTE_RST;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `IAPF_OFF_CTRL0:  reg_rdata <= {flag_reg, mode_reg, trig_reg, winit_reg,
                                        rden_reg, rinit_reg};
        `IAPF_OFF_RSTPAT: reg_rdata <= rstpat_reg;
        `IAPF_OFF_CTRL2:  reg_rdata <= {6'h00, tsel_reg, clr_reg};
        `IAPF_OFF_ADRL:   reg_rdata <= addr_reg[7:0];
        `IAPF_OFF_ADRH:   reg_rdata <= {4'h0, addr_reg[11:8]};
        4'h5, 4'h7, 4'h9, 4'hb: begin
          reg_rdata <= data_reg[2'(4'(reg_req.addr - `IAPF_OFF_DAT0L) >> 1)][7:0];
        end
        4'h6, 4'h8, 4'ha, 4'hc: begin
          reg_rdata <= data_reg[2'(4'(reg_req.addr - `IAPF_OFF_DAT0L) >> 1)][15:8];
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : iapf_ctrl

/* test/iapf_flash_model.sv */
// Behavioural flash array on the far side of the controller
`timescale 1ns/1ps
module iapf_flash_model
  import iapf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        flash_erase,
  input  wire logic [6:0]  flash_page,
  input  wire iapf_word_t  flash_wr,
  input  wire logic        flash_wr_valid,
  output logic             flash_wr_ready,
  input  wire logic        flash_rd_req,
  input  wire logic [11:0] flash_rd_addr,
  output logic             flash_rd_valid,
  output logic [15:0]      flash_rd_data
);
  logic [15:0] mem [4096];
  logic        ph;
  logic [1:0]  cnt;

  // Stalls every other cycle when slow
  assign flash_wr_ready = !slow || ph;

  always @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4096; i++) mem[i] = 16'h0f0f;
      ph <= 1'b0;
      cnt <= 2'h0;
      flash_rd_valid <= 1'b0;
      flash_rd_data <= 16'h0000;
    end else begin
      ph <= !ph;
      flash_rd_valid <= 1'b0;
      // Released data line keeps toggling
      flash_rd_data <= ~flash_rd_data;
      if (flash_erase)
        for (int i = 0; i < 32; i++) mem[{flash_page, i[4:0]}] = 16'hffff;
      // Programming only clears bits
      if (flash_wr_valid && flash_wr_ready)
        mem[flash_wr.addr] = mem[flash_wr.addr] & flash_wr.data;
      if (flash_rd_req && !flash_rd_valid) begin
        cnt <= cnt + 2'h1;
        if (cnt == (slow ? 2'h3 : 2'h0)) begin
          flash_rd_valid <= 1'b1;
          flash_rd_data <= mem[flash_rd_addr];
          cnt <= 2'h0;
        end
      end
    end
  end
endmodule : iapf_flash_model

/* test/iapf_ctrl_sva.sv */
// Port checker of the flash program controller
`timescale 1ns/1ps
module iapf_ctrl_sva
  import iapf_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire iapf_reg_req_t reg_req,
  input wire logic [7:0]    reg_rdata,
  input wire logic          cpu_halt,
  input wire logic          flash_erase,
  input wire logic          flash_prog,
  input wire logic [6:0]    flash_page,
  input wire iapf_word_t    flash_wr,
  input wire logic          flash_wr_valid,
  input wire logic          flash_wr_ready,
  input wire logic          flash_rd_req,
  input wire logic [11:0]   flash_rd_addr,
  input wire logic          flash_rd_valid,
  input wire logic [15:0]   flash_rd_data
);
  logic [5:0] wcnt;

  // Words handed over in this operation
  always_ff @(posedge clk) begin
    if (!rst_n || !cpu_halt) wcnt <= 6'h00;
    else if (flash_wr_valid && flash_wr_ready) wcnt <= wcnt + 6'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==================================================
  // Assertions
  page_addr_a: assert property (flash_page == flash_rd_addr[11:5])
    else $error("page differs from address");
  halt_busy_a: assert property ((flash_erase || flash_prog || flash_rd_req
    || flash_wr_valid) |-> cpu_halt) else $error("operation without halt");
  erase_prog_a: assert property (!(flash_erase && flash_prog))
    else $error("erase and program together");
  rd_hold_a: assert property (flash_rd_req && !flash_rd_valid |=> flash_rd_req)
    else $error("read request dropped early");
  rd_done_a: assert property (flash_rd_req && flash_rd_valid |=>
    !flash_rd_req && !cpu_halt) else $error("read did not end");
  wr_hold_a: assert property (flash_wr_valid && !flash_wr_ready |=>
    flash_wr_valid && $stable(flash_wr)) else $error("word changed while stalled");
  prog_count_a: assert property ($rose(flash_prog) |-> wcnt == 6'h20)
    else $error("program began without a full page");
  wr_order_a: assert property (flash_wr_valid && flash_wr_ready |->
    flash_wr.addr == {flash_page, wcnt[4:0]}) else $error("word out of order");
  op_end_a: assert property ($fell(flash_prog) || $fell(flash_erase)
    |-> !cpu_halt) else $error("halt kept after operation");
  unmapped_a: assert property (reg_req.rd && reg_req.addr > 4'hc |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");

  erase_c: cover property ($fell(flash_erase));
  prog_c: cover property ($fell(flash_prog));
  read_c: cover property (flash_rd_req && flash_rd_valid);
endmodule : iapf_ctrl_sva

bind iapf_ctrl iapf_ctrl_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .cpu_halt(cpu_halt), .flash_erase(flash_erase),
  .flash_prog(flash_prog), .flash_page(flash_page), .flash_wr(flash_wr),
  .flash_wr_valid(flash_wr_valid), .flash_wr_ready(flash_wr_ready),
  .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
  .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data));

/* test/tb_iap_flash_program_controller.sv */
// Self-checking bench of the flash program controller
`timescale 1ns/1ps
`include "iapf_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_iap_flash_program_controller
  import iapf_pkg::*;
;
  localparam logic [15:0] PAT [3] = '{16'h1234, 16'h5678, 16'h9abc};
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          slow = 1'b0;
  iapf_reg_req_t req = '0;
  logic [7:0]    rdata;
  logic          halt, er, pg, wv, wrdy, rq, rv;
  logic [6:0]    page;
  logic [11:0]   raddr;
  logic [15:0]   rdat;
  iapf_word_t    wword;
  int            mismatches = 0;
  int            n_compared = 0;
  int            ercnt = 0;
  iapf_word_t    got [$];

  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (er || pg) ercnt++;
    if (wv && wrdy) got.push_back(wword);
  end

  iapf_ctrl #(.ERASE0_CYC(20), .ERASE1_CYC(30), .WRITE0_CYC(25), .WRITE1_CYC(35),
    .ENABLE_CYC(32), .UNLOCK_PAT1(PAT[0]), .UNLOCK_PAT2(PAT[1]), .UNLOCK_PAT3(PAT[2]))
    DUT (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .cpu_halt(halt),
    .flash_erase(er), .flash_prog(pg), .flash_page(page), .flash_wr(wword),
    .flash_wr_valid(wv), .flash_wr_ready(wrdy), .flash_rd_req(rq),
    .flash_rd_addr(raddr), .flash_rd_valid(rv), .flash_rd_data(rdat));
  iapf_flash_model u_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .flash_erase(er),
    .flash_page(page), .flash_wr(wword), .flash_wr_valid(wv), .flash_wr_ready(wrdy),
    .flash_rd_req(rq), .flash_rd_addr(raddr), .flash_rd_valid(rv),
    .flash_rd_data(rdat));

  // ==================================================
  // Bus and closing tasks
  task automatic test_done;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) req <= {1'b1, 1'b0, a, d};
    // Strobe lasts one cycle, so a late hardware clear shows on the next read
    @(posedge clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    @(posedge clk) #1 d = rdata;
  endtask : rd
  task automatic poll(input logic [3:0] a, input int b);
    logic [7:0] d;
    for (int i = 0; i < 400; i++) begin
      rd(a, d);
      if (d[b] === 1'b0) return;
    end
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask : poll
  task automatic prog_page(input logic [15:0] b, input logic [15:0] k);
    got.delete();
    ercnt = 0;
    wr(`IAPF_OFF_ADRL, 8'h60);
    wr(`IAPF_OFF_CTRL0, 8'h84);
    poll(`IAPF_OFF_CTRL0, 2);
    `CHK(ercnt, 25)
    `CHK(got.size(), 32)
    foreach (got[i]) `CHK(got[i], {12'h060 + 12'(i), b + 16'(i) * k})
  endtask : prog_page

  // ==================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] d;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      `CHK(d, 8'h00)
    end
    wr(`IAPF_OFF_CTRL0, 8'h80);
    wr(`IAPF_OFF_DAT0H, 8'h12);
    rd(`IAPF_OFF_CTRL0, d);
    `CHK(d, 8'h00)
    rd(`IAPF_OFF_ADRL, d);
    `CHK(d, 8'h00)
  endtask : t_reset
  task automatic t_enable;
    logic [7:0] d;
    wr(`IAPF_OFF_CTRL0, 8'h68);
    poll(`IAPF_OFF_CTRL0, 3);
    rd(`IAPF_OFF_CTRL0, d);
    `CHK(d, 8'h60)
    wr(`IAPF_OFF_CTRL0, 8'h68);
    rd(`IAPF_OFF_CTRL0, d);
    `CHK(d, 8'h68)
    for (int i = 0; i < 3; i++) begin
      wr(4'(7 + 2 * i), PAT[i][7:0]);
      wr(4'(8 + 2 * i), PAT[i][15:8]);
    end
    poll(`IAPF_OFF_CTRL0, 3);
    rd(`IAPF_OFF_CTRL0, d);
    `CHK(d, 8'he0)
  endtask : t_enable
  task automatic t_erase;
    for (int t = 0; t < 2; t++) begin
      ercnt = 0;
      wr(`IAPF_OFF_CTRL2, 8'(2 * t));
      wr(`IAPF_OFF_ADRL, 8'h60);
      wr(`IAPF_OFF_CTRL0, 8'h94);
      poll(`IAPF_OFF_CTRL0, 2);
      `CHK(ercnt, t ? 30 : 20)
    end
  endtask : t_erase
  task automatic t_fill;
    logic [7:0] d;
    wr(`IAPF_OFF_CTRL2, 8'h01);
    rd(`IAPF_OFF_CTRL2, d);
    `CHK(d, 8'h00)
    wr(`IAPF_OFF_ADRL, 8'h60);
    for (int i = 0; i < 33; i++) begin
      wr(`IAPF_OFF_DAT0L, 8'(i < 32 ? i : 31));
      wr(`IAPF_OFF_DAT0H, 8'ha5);
      if (i == 0) begin
        rd(`IAPF_OFF_ADRL, d);
        `CHK(d, 8'h61)
      end
    end
    rd(`IAPF_OFF_ADRL, d);
    `CHK(d, 8'h7f)
    rd(`IAPF_OFF_ADRH, d);
    `CHK(d, 8'h00)
    slow = 1'b1;
    prog_page(16'ha500, 16'h0001);
  endtask : t_fill
  task automatic t_read;
    logic [7:0] d;
    for (int i = 0; i < 2; i++) begin
      slow = (i == 0);
      wr(`IAPF_OFF_ADRL, i ? 8'h7f : 8'h65);
      wr(`IAPF_OFF_CTRL0, 8'hb2);
      wr(`IAPF_OFF_CTRL0, 8'hb3);
      poll(`IAPF_OFF_CTRL0, 0);
      rd(`IAPF_OFF_DAT0L, d);
      `CHK(d, i ? 8'h1f : 8'h05)
      rd(`IAPF_OFF_DAT0H, d);
      `CHK(d, 8'ha5)
    end
  endtask : t_read
  task automatic t_refuse;
    logic [7:0] d;
    wr(`IAPF_OFF_CTRL0, 8'ha4);
    rd(`IAPF_OFF_CTRL0, d);
    `CHK(d, 8'ha0)
    wr(`IAPF_OFF_CTRL0, 8'hb1);
    rd(`IAPF_OFF_CTRL0, d);
    `CHK(d, 8'hb0)
    prog_page(16'h0000, 16'h0000);
    wr(`IAPF_OFF_DAT0H, 8'h77);
    wr(`IAPF_OFF_CTRL2, 8'h01);
    prog_page(16'h0000, 16'h0000);
    wr(`IAPF_OFF_CTRL0, 8'h00);
    wr(`IAPF_OFF_ADRL, 8'h40);
    wr(`IAPF_OFF_DAT0H, 8'h77);
    rd(`IAPF_OFF_ADRL, d);
    `CHK(d, 8'h40)
  endtask : t_refuse

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_enable();
    t_erase();
    t_fill();
    t_read();
    t_refuse();
    test_done();
  end
endmodule : tb_iap_flash_program_controller
